// ### rtl/itac_regs.svh
// Purpose: register indices, field positions, reset values of the indirect access front-end
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef ITAC_REGS_SVH
`define ITAC_REGS_SVH

// Register indices
`define ITAC_IDX_CMD_CTRL  8'h6e
`define ITAC_IDX_ADDR_LOW  8'h6f
`define ITAC_IDX_DATA_TOP  8'h70
`define ITAC_IDX_DATA_LOW  8'h78
`define ITAC_IDX_STATUS    8'h7e

// Bus geometry
`define ITAC_AXI_ADDR_W    10
`define ITAC_DATA_W        69
`define ITAC_DATA_BYTES    9

// Command control fields
`define ITAC_SEL_HI        7
`define ITAC_SEL_LO        5
`define ITAC_DIR_BIT       4
`define ITAC_TSEL_HI       3
`define ITAC_TSEL_LO       2
`define ITAC_AHI_HI        1
`define ITAC_AHI_LO        0

// Target-space selector codes
`define ITAC_SEL_TABLE     3'h0
`define ITAC_SEL_ENERGY    3'h1
`define ITAC_SEL_ACCESS    3'h2
`define ITAC_SEL_RSVD      3'h3
`define ITAC_SEL_WAKE      3'h4
`define ITAC_SEL_CABLE     3'h5

// Table selector codes
`define ITAC_TBL_STATIC    2'h0
`define ITAC_TBL_VLAN      2'h1
`define ITAC_TBL_DYNAMIC   2'h2
`define ITAC_TBL_COUNTER   2'h3

// Reset values
`define ITAC_CMD_CTRL_RST  8'h00
`define ITAC_ADDR_LOW_RST  8'h00
`define ITAC_DATA_RST      69'h0

// Status bits
`define ITAC_ST_BUSY       0
`define ITAC_ST_RSVD_ERR   1
`define ITAC_ST_LAST_READ  2
`define ITAC_ST_OVERRUN    3

// Bus responses
`define ITAC_RESP_OKAY     2'h0
`define ITAC_RESP_SLVERR   2'h2

`endif

// ### rtl/itac_pkg.sv
// Purpose: types shared by the indirect access front-end
// Assumes: nothing
// Notes:   target enumeration is carried on the command port
package itac_pkg;

  typedef enum logic [3:0] {
    itac_tgt_static,
    itac_tgt_vlan,
    itac_tgt_dynamic,
    itac_tgt_counter,
    itac_tgt_energy,
    itac_tgt_access,
    itac_tgt_wake,
    itac_tgt_cable,
    itac_tgt_none
  } itac_target_e;

  typedef enum logic {
    itac_idle,
    itac_wait
  } itac_state_e;

  typedef logic [11:0] itac_addr_t;

endpackage

// ### rtl/itac_decode.sv
// Purpose: decode command control and low address byte into target and 12-bit address
// Assumes: purely combinational, evaluated at launch
// Notes:   selector codes 3, 6 and 7 decode as no target
`timescale 1ns/1ps
`include "itac_regs.svh"

module itac_decode (
  // Programmed values
  input  wire logic [7:0]                 ctrl,
  input  wire logic [7:0]                 addr_low,
  // Decoded command
  output itac_pkg::itac_target_e          target,
  output itac_pkg::itac_addr_t            addr,
  output logic      [3:0]                 port,
  output logic      [7:0]                 reg_ptr,
  output logic                            legal,
  output logic                            port_known
);
  import itac_pkg::*;

  logic [2:0] sel;
  logic [1:0] tsel;

  assign sel  = ctrl[`ITAC_SEL_HI:`ITAC_SEL_LO];
  assign tsel = ctrl[`ITAC_TSEL_HI:`ITAC_TSEL_LO];

  always_comb begin
    // Table mode folds bits 3:2 into a selector, else they are address 11:10
    if (sel == `ITAC_SEL_TABLE) begin
      addr = {2'h0, ctrl[`ITAC_AHI_HI:`ITAC_AHI_LO], addr_low};
    end else begin
      addr = {tsel, ctrl[`ITAC_AHI_HI:`ITAC_AHI_LO], addr_low};
    end
    port    = addr[11:8];
    reg_ptr = addr[7:0];
    legal   = 1'b1;
    unique case (sel)
      `ITAC_SEL_TABLE: begin
        unique case (tsel)
          `ITAC_TBL_STATIC:  target = itac_tgt_static;
          `ITAC_TBL_VLAN:    target = itac_tgt_vlan;
          `ITAC_TBL_DYNAMIC: target = itac_tgt_dynamic;
          `ITAC_TBL_COUNTER: target = itac_tgt_counter;
        endcase
      end
      `ITAC_SEL_ENERGY: target = itac_tgt_energy;
      `ITAC_SEL_ACCESS: target = itac_tgt_access;
      `ITAC_SEL_WAKE:   target = itac_tgt_wake;
      `ITAC_SEL_CABLE:  target = itac_tgt_cable;
      default: begin
        target = itac_tgt_none;
        legal  = 1'b0;
      end
    endcase
    // Global, port 1, 2, 4 and 5 register spaces
    unique case (port)
      4'h0, 4'h1, 4'h2, 4'h4, 4'h5: port_known = 1'b1;
      default:                      port_known = 1'b0;
    endcase
  end

endmodule

// ### rtl/itac_top.sv
// Purpose: AXI4-Lite front-end that launches indirect table and register commands
// Assumes: one command engine outside answers each start with one cmd_done pulse
// Notes:   a write to the low address register is the only launch
// Behaviour
// - Selector 000 makes control bits 3:2 a table selector.
// - Selector 001 targets energy-efficient registers; port in address 11:8, pointer 7:0.
// - Selector 010 targets per-port access-list registers, same port and pointer split.
// - Selector 100 targets wake-event registers; 011 is reserved and not launched.
// - Selector 101 sends the command to cable diagnosis.
// - Control bit 4 chooses read when one, write when zero.
// - Table selector 00 static, 01 VLAN, 10 dynamic, 11 statistics counters.
// - Nonzero selector makes bits 3:2 address 11:10; 11:8 port, 7:0 register.
// - Port field 0000 global, 0001 port one, 0010 port two, 0100, 0101.
// - Control bits 1:0 hold indirect address bits 9:8.
// - Low address register holds address 7:0 and resets to zero.
// - Only a low address write launches; software writes it last.
// - Indirect data is 69 bits across nine byte registers, top holds 68:64.
`timescale 1ns/1ps
`include "itac_regs.svh"

module itac_top (
  // Clock and reset
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  // AXI4-Lite write address
  input  wire logic [`ITAC_AXI_ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]                        s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [`ITAC_AXI_ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  // AXI4-Lite read data
  output logic      [31:0]                       s_axi_rdata,
  output logic      [1:0]                        s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  // Command to table engine
  output logic                                   cmd_start,
  output logic                                   cmd_read,
  output itac_pkg::itac_target_e                 cmd_target,
  output itac_pkg::itac_addr_t                   cmd_addr,
  output logic      [3:0]                        cmd_port,
  output logic      [7:0]                        cmd_reg_ptr,
  output logic                                   cmd_port_known,
  output logic      [`ITAC_DATA_W-1:0]           cmd_wdata,
  // Answer from table engine
  input  wire logic                              cmd_done,
  input  wire logic [`ITAC_DATA_W-1:0]           cmd_rdata
);
  import itac_pkg::*;

  // Bus side state
  logic                            awready_ff;
  logic                            wready_ff;
  logic                            bvalid_ff;
  logic [1:0]                      bresp_ff;
  logic                            arready_ff;
  logic                            rvalid_ff;
  logic [1:0]                      rresp_ff;
  logic [31:0]                     rdata_ff;
  logic                            aw_held_ff;
  logic [7:0]                      aw_idx_ff;
  logic                            w_held_ff;
  logic [7:0]                      w_byte_ff;
  logic                            w_lane_ff;
  // Register file
  logic [7:0]                      ctrl_ff;
  logic [7:0]                      addr_low_ff;
  logic [`ITAC_DATA_W-1:0]         data_ff;
  logic                            rsvd_err_ff;
  logic                            overrun_ff;
  logic                            last_read_ff;
  // Command side
  itac_state_e                     state_ff;
  logic                            start_ff;
  logic                            read_ff;
  itac_target_e                    target_ff;
  itac_addr_t                      addr_ff;
  logic [3:0]                      port_ff;
  logic [7:0]                      reg_ptr_ff;
  logic                            port_known_ff;
  // Combinational
  logic                            aw_take;
  logic                            w_take;
  logic                            ar_take;
  logic                            wr_fire;
  logic                            wr_en;
  logic                            wr_mapped;
  logic                            launch_req;
  logic                            busy;
  logic                            launch_ok;
  logic                            load_rd;
  logic [7:0]                      ar_idx;
  logic [8*`ITAC_DATA_BYTES-1:0]   data_pad;
  logic [8*`ITAC_DATA_BYTES-1:0]   rdata_pad;
  logic [8*`ITAC_DATA_BYTES-1:0]   nxt_data_pad;
  itac_target_e                    dec_target;
  itac_addr_t                      dec_addr;
  logic [3:0]                      dec_port;
  logic [7:0]                      dec_reg_ptr;
  logic                            dec_legal;
  logic                            dec_port_known;

  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx == `ITAC_IDX_CMD_CTRL) || (idx == `ITAC_IDX_ADDR_LOW) ||
                (idx == `ITAC_IDX_STATUS) ||
                ((idx >= `ITAC_IDX_DATA_TOP) && (idx <= `ITAC_IDX_DATA_LOW));
  endfunction

  assign aw_take    = s_axi_awvalid & awready_ff;
  assign w_take     = s_axi_wvalid & wready_ff;
  assign ar_take    = s_axi_arvalid & arready_ff;
  assign ar_idx     = s_axi_araddr[`ITAC_AXI_ADDR_W-1:2];
  assign wr_fire    = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_mapped  = is_mapped(aw_idx_ff);
  assign wr_en      = wr_fire & w_lane_ff & wr_mapped;
  assign busy       = (state_ff == itac_wait) | start_ff;
  assign launch_req = wr_en & (aw_idx_ff == `ITAC_IDX_ADDR_LOW);
  assign launch_ok  = launch_req & ~busy & dec_legal;
  assign load_rd    = (state_ff == itac_wait) & cmd_done & read_ff;
  assign data_pad   = {{(8*`ITAC_DATA_BYTES-`ITAC_DATA_W){1'b0}}, data_ff};
  assign rdata_pad  = {{(8*`ITAC_DATA_BYTES-`ITAC_DATA_W){1'b0}}, cmd_rdata};

  itac_decode u_decode (
    .ctrl       (ctrl_ff),
    .addr_low   (w_byte_ff),
    .target     (dec_target),
    .addr       (dec_addr),
    .port       (dec_port),
    .reg_ptr    (dec_reg_ptr),
    .legal      (dec_legal),
    .port_known (dec_port_known)
  );

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      aw_idx_ff  <= 8'h00;
      w_byte_ff  <= 8'h00;
      w_lane_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `ITAC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        awready_ff <= 1'b0;
        aw_held_ff <= 1'b1;
        aw_idx_ff  <= s_axi_awaddr[`ITAC_AXI_ADDR_W-1:2];
      end
      if (w_take) begin
        wready_ff <= 1'b0;
        w_held_ff <= 1'b1;
        w_byte_ff <= s_axi_wdata[7:0];
        w_lane_ff <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        // Unmapped index or launch while busy is refused
        bresp_ff   <= (!wr_mapped || (launch_req && busy)) ? `ITAC_RESP_SLVERR : `ITAC_RESP_OKAY;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // Read channel: data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= `ITAC_RESP_OKAY;
      rdata_ff   <= 32'h0;
    end else begin
      if (ar_take) begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rresp_ff   <= is_mapped(ar_idx) ? `ITAC_RESP_OKAY : `ITAC_RESP_SLVERR;
        rdata_ff   <= 32'h0;
        if (ar_idx == `ITAC_IDX_CMD_CTRL) begin
          rdata_ff[7:0] <= ctrl_ff;
        end else if (ar_idx == `ITAC_IDX_ADDR_LOW) begin
          rdata_ff[7:0] <= addr_low_ff;
        end else if (ar_idx == `ITAC_IDX_STATUS) begin
          rdata_ff[`ITAC_ST_BUSY]      <= busy;
          rdata_ff[`ITAC_ST_RSVD_ERR]  <= rsvd_err_ff;
          rdata_ff[`ITAC_ST_LAST_READ] <= last_read_ff;
          rdata_ff[`ITAC_ST_OVERRUN]   <= overrun_ff;
        end else if (is_mapped(ar_idx)) begin
          // Index 0x70 holds the top five bits, 0x78 the lowest byte
          rdata_ff[7:0] <= data_pad[8*(`ITAC_IDX_DATA_LOW - ar_idx) +: 8];
        end
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff     <= `ITAC_CMD_CTRL_RST;
      addr_low_ff <= `ITAC_ADDR_LOW_RST;
    end else begin
      if (wr_en && aw_idx_ff == `ITAC_IDX_CMD_CTRL) begin
        ctrl_ff <= w_byte_ff;
      end
      if (launch_req && !busy) begin
        addr_low_ff <= w_byte_ff;
      end
    end
  end

  // Data bytes: engine load on a read answer wins over a software write
  generate
    for (genvar i = 0; i < `ITAC_DATA_BYTES; i++) begin : g_byte
      logic byte_we;
      assign byte_we = wr_en && (aw_idx_ff == `ITAC_IDX_DATA_LOW - 8'(i));
      assign nxt_data_pad[8*i +: 8] = load_rd ? rdata_pad[8*i +: 8] :
                                      byte_we ? w_byte_ff : data_pad[8*i +: 8];
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_ff <= `ITAC_DATA_RST;
    end else begin
      data_ff <= nxt_data_pad[`ITAC_DATA_W-1:0];
    end
  end

  // Sticky status; a new launch clears, a new fault sets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsvd_err_ff  <= 1'b0;
      overrun_ff   <= 1'b0;
      last_read_ff <= 1'b0;
    end else begin
      if (launch_ok) begin
        rsvd_err_ff  <= 1'b0;
        overrun_ff   <= 1'b0;
        last_read_ff <= ctrl_ff[`ITAC_DIR_BIT];
      end
      if (launch_req && !busy && !dec_legal) begin
        rsvd_err_ff <= 1'b1;
      end
      if (launch_req && busy) begin
        overrun_ff <= 1'b1;
      end
    end
  end

  // Command sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= itac_idle;
    end else begin
      unique case (state_ff)
        itac_idle: if (launch_ok) state_ff <= itac_wait;
        itac_wait: if (cmd_done)  state_ff <= itac_idle;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_ff      <= 1'b0;
      read_ff       <= 1'b0;
      target_ff     <= itac_tgt_none;
      addr_ff       <= 12'h000;
      port_ff       <= 4'h0;
      reg_ptr_ff    <= 8'h00;
      port_known_ff <= 1'b0;
    end else begin
      start_ff <= launch_ok;
      if (launch_ok) begin
        read_ff       <= ctrl_ff[`ITAC_DIR_BIT];
        target_ff     <= dec_target;
        addr_ff       <= dec_addr;
        port_ff       <= dec_port;
        reg_ptr_ff    <= dec_reg_ptr;
        port_known_ff <= dec_port_known;
      end
    end
  end

  assign s_axi_awready  = awready_ff;
  assign s_axi_wready   = wready_ff;
  assign s_axi_bvalid   = bvalid_ff;
  assign s_axi_bresp    = bresp_ff;
  assign s_axi_arready  = arready_ff;
  assign s_axi_rvalid   = rvalid_ff;
  assign s_axi_rresp    = rresp_ff;
  assign s_axi_rdata    = rdata_ff;
  assign cmd_start      = start_ff;
  assign cmd_read       = read_ff;
  assign cmd_target     = target_ff;
  assign cmd_addr       = addr_ff;
  assign cmd_port       = port_ff;
  assign cmd_reg_ptr    = reg_ptr_ff;
  assign cmd_port_known = port_known_ff;
  assign cmd_wdata      = data_ff;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_launch_start: assert property (launch_ok |=> cmd_start && !$past(busy))
    else $error("launch did not start a command");
  a_start_source: assert property (cmd_start |-> $past(launch_req))
    else $error("command started without low address write");
  a_dir_copy: assert property (cmd_start |-> cmd_read == $past(ctrl_ff[`ITAC_DIR_BIT]))
    else $error("command direction differs from control bit");
  a_no_reserved: assert property (cmd_start |-> cmd_target != itac_tgt_none)
    else $error("reserved selector launched");
  a_addr_low: assert property (cmd_start |-> cmd_addr[7:0] == addr_low_ff)
    else $error("low address not carried by command");
  a_addr_hi: assert property (
    launch_ok && ctrl_ff[`ITAC_SEL_HI:`ITAC_SEL_LO] != `ITAC_SEL_TABLE
    |=> cmd_addr[11:8] == $past(ctrl_ff[3:0]) && cmd_port == cmd_addr[11:8])
    else $error("upper address bits wrong");
  a_table_map: assert property (
    launch_ok && ctrl_ff[`ITAC_SEL_HI:`ITAC_SEL_LO] == `ITAC_SEL_TABLE && ctrl_ff[3:2] == `ITAC_TBL_COUNTER
    |=> cmd_target == itac_tgt_counter && cmd_addr[11:10] == 2'h0)
    else $error("table selector decoded wrong");
  a_read_load: assert property (load_rd |=> data_ff == $past(cmd_rdata) && state_ff == itac_idle)
    else $error("read answer not loaded");
  a_top_byte: assert property (
    ar_take && ar_idx == `ITAC_IDX_DATA_TOP |=> s_axi_rdata[31:5] == 27'h0)
    else $error("top data register wider than five bits");
  a_write_resp: assert property (wr_fire |=> s_axi_bvalid [*1] ##0 !s_axi_awready)
    else $error("write response late");

  c_read_cmd:  cover property (cmd_start && cmd_read ##[1:20] load_rd);
  c_write_cmd: cover property (cmd_start && !cmd_read);
  c_reserved:  cover property (launch_req && !dec_legal);
  c_overrun:   cover property (launch_req && busy);

endmodule

// ### bench/test_itac_top.sv
// Purpose: self-checking bench for the indirect access front-end
// Assumes: bench plays the table engine on the command port
// Notes:   all register traffic goes over AXI4-Lite
`timescale 1ns/1ps
`include "itac_regs.svh"

module test_itac_top;
  import itac_pkg::*;
  logic         aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic         cmd_start, cmd_read, cmd_port_known, cmd_done, st;
  logic [9:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]   s_axi_wstrb, cmd_port;
  logic [1:0]   s_axi_bresp, s_axi_rresp, resp;
  logic [7:0]   cmd_reg_ptr, rd;
  itac_addr_t   cmd_addr;
  logic [68:0]  cmd_wdata, cmd_rdata;
  itac_target_e cmd_target;
  int           n_errors, check_count, cyc;

  itac_top u_itac_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cmd_start, .cmd_read, .cmd_target, .cmd_addr, .cmd_port, .cmd_reg_ptr, .cmd_port_known,
    .cmd_wdata, .cmd_done, .cmd_rdata
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("Checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [68:0] seen, input logic [68:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write one byte; st keeps cmd_start as seen with the response
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    st = cmd_start;
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_reg(input logic [7:0] idx);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Engine ends the running command
  task automatic done(input logic [68:0] d);
    cmd_rdata <= d;
    cmd_done  <= 1'b1;
    @(posedge aclk);
    cmd_done <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic t_reset;
    rd_reg(`ITAC_IDX_ADDR_LOW);
    chk("addr_low", rd, 0);
    rd_reg(`ITAC_IDX_CMD_CTRL);
    chk("cmd_ctrl", rd, 0);
    rd_reg(8'h10);
    chk("unmapped", resp, `ITAC_RESP_SLVERR);
    chk("unmapped_data", rd, 0);
    wr(8'h10, 8'h33);
    chk("unmapped_wr", resp, `ITAC_RESP_SLVERR);
    chk("unmapped_st", st, 0);
  endtask

  task automatic t_table;
    for (int t = 0; t < 4; t++) begin
      wr(`ITAC_IDX_CMD_CTRL, {3'h0, t[0], t[1:0], 2'h2});
      chk("ctrl_launch", st, 0);
      wr(`ITAC_IDX_ADDR_LOW, 8'ha5);
      chk("launch", st, 1);
      chk("launch_resp", resp, `ITAC_RESP_OKAY);
      chk("read", cmd_read, t[0]);
      chk("target", cmd_target, t);
      chk("addr", cmd_addr, 12'h2a5);
      done(0);
    end
  endtask

  task automatic t_space;
    logic [2:0] sel [6] = '{1, 2, 4, 5, 2, 1};
    logic [3:0] prt [6] = '{0, 1, 2, 4, 5, 6};
    int         tgt [6] = '{4, 5, 6, 7, 5, 4};
    for (int i = 0; i < 6; i++) begin
      wr(`ITAC_IDX_CMD_CTRL, {sel[i], 1'b1, prt[i]});
      wr(`ITAC_IDX_ADDR_LOW, 8'h30 + 8'(i));
      chk("target", cmd_target, tgt[i]);
      chk("addr", cmd_addr, {prt[i], 8'h30 + 8'(i)});
      chk("port", cmd_port, prt[i]);
      chk("ptr", cmd_reg_ptr, 8'h30 + 8'(i));
      chk("known", cmd_port_known, i < 5);
      chk("read", cmd_read, 1);
      done(0);
    end
  endtask

  task automatic t_reserved_busy;
    wr(`ITAC_IDX_CMD_CTRL, 8'h60);
    wr(`ITAC_IDX_ADDR_LOW, 8'h01);
    chk("rsvd_launch", st, 0);
    chk("rsvd_resp", resp, `ITAC_RESP_OKAY);
    rd_reg(`ITAC_IDX_STATUS);
    chk("rsvd_flag", rd[1], 1);
    wr(`ITAC_IDX_CMD_CTRL, 8'h10);
    wr(`ITAC_IDX_ADDR_LOW, 8'h07);
    wr(`ITAC_IDX_ADDR_LOW, 8'h08);
    chk("busy_resp", resp, `ITAC_RESP_SLVERR);
    chk("busy_launch", st, 0);
    // Busy, last read and overrun set; reserved flag cleared by the launch
    rd_reg(`ITAC_IDX_STATUS);
    chk("busy_status", rd[3:0], 4'hd);
    done(0);
    rd_reg(`ITAC_IDX_ADDR_LOW);
    chk("low_kept", rd, 8'h07);
    // Lane 0 not strobed: no store, no launch
    s_axi_wstrb <= 4'h0;
    wr(`ITAC_IDX_ADDR_LOW, 8'h55);
    chk("strb_launch", st, 0);
    chk("strb_resp", resp, `ITAC_RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    rd_reg(`ITAC_IDX_ADDR_LOW);
    chk("strb_kept", rd, 8'h07);
  endtask

  task automatic t_data;
    wr(`ITAC_IDX_DATA_TOP, 8'hff);
    wr(`ITAC_IDX_DATA_LOW, 8'h5a);
    wr(`ITAC_IDX_CMD_CTRL, 8'h20);
    wr(`ITAC_IDX_ADDR_LOW, 8'h11);
    chk("wdata_top", cmd_wdata[68:64], 5'h1f);
    chk("wdata_low", cmd_wdata[7:0], 8'h5a);
    done({5'h1a, 64'h0123456789abcdef});
    rd_reg(`ITAC_IDX_DATA_LOW);
    chk("no_load", rd, 8'h5a);
    wr(`ITAC_IDX_CMD_CTRL, 8'h30);
    wr(`ITAC_IDX_ADDR_LOW, 8'h12);
    done({5'h1a, 64'h0123456789abcdef});
    rd_reg(`ITAC_IDX_DATA_TOP);
    chk("rdata_top", rd, 8'h1a);
    rd_reg(8'h71);
    chk("rdata_63", rd, 8'h01);
    rd_reg(`ITAC_IDX_DATA_LOW);
    chk("rdata_low", rd, 8'hef);
    chk("rresp", resp, `ITAC_RESP_OKAY);
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, cmd_done} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata  = '0;
    s_axi_wstrb  = 4'h1;
    cmd_rdata    = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_table();
    t_space();
    t_reserved_busy();
    t_data();
    wrap_up();
  end
endmodule
